// [hdl/sarseq_top.sv]
// sar converter sequencer, control/status and result registers
`timescale 1ns/10ps
`default_nettype none

module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int RESULT_BITS = 10
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic standby,
  input wire sarseq_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic ext_trigger_pin,
  input wire logic ext_trigger_rising,
  input wire logic [RESULT_BITS-1:0] conv_data_in,
  output logic [1:0] analog_channel,
  output logic conv_active,
  output logic sample_strobe,
  output logic conv_end_irq
);

  if (RESULT_BITS != 10)
  begin : g_bad_width
    $error("sarseq_top: only a 10-bit result is supported");
  end

  localparam logic [SARSEQ_TIMER_W-1:0] SLOW_LAST = SARSEQ_TIMER_W'(SARSEQ_CONV_SLOW_CYC - 1);
  localparam logic [SARSEQ_TIMER_W-1:0] FAST_LAST = SARSEQ_TIMER_W'(SARSEQ_CONV_FAST_CYC - 1);

  sarseq_regs_t s_reg;
  sarseq_regs_t s_next;
  sarseq_regs_t s_reset;

  logic [7:0] csr_view;
  logic [15:0] res_word;
  logic trig_edge;
  logic conv_done;
  logic last_ch;

  always_comb
  begin
    s_reset = '0;
    s_reset.fsm = SARSEQ_IDLE;
    s_reset.trig_prev = 1'b0;
  end

  // register image of the control/status byte
  assign csr_view = {s_reg.flag, s_reg.irq_en, s_reg.start, s_reg.scan, s_reg.conv_time_select, s_reg.chsel};

  // addressed channel result aligned to 16 bits
  assign res_word = {s_reg.result[bus_req.addr[2:1]], 6'h00};

  // chosen edge of the trigger pin while enabled
  assign trig_edge = s_reg.trig_en && (ext_trigger_rising ? (ext_trigger_pin && !s_reg.trig_prev)
                                                          : (!ext_trigger_pin && s_reg.trig_prev));

  assign conv_done = (s_reg.fsm == SARSEQ_CONV) && (s_reg.timer == (s_reg.conv_time_select ? FAST_LAST : SLOW_LAST));
  assign last_ch = !s_reg.scan || (s_reg.ch == s_reg.chsel[1:0]);

  always_comb
  begin
    s_next = s_reg;
    s_next.trig_prev = ext_trigger_pin;

    // register reads and their side effects
    if (bus_req.rd)
    begin
      if (bus_req.addr <= SARSEQ_OFS_RES3_LO)
      begin
        if (!bus_req.addr[0])
        begin
          s_next.rdata = res_word[15:8];
          s_next.hold = res_word[7:0];
        end
        else
        begin
          s_next.rdata = s_reg.hold;
        end
      end
      else if (bus_req.addr == SARSEQ_OFS_CSR)
      begin
        s_next.rdata = csr_view;
        if (s_reg.flag)
        begin
          s_next.flag_armed = 1'b1;
        end
      end
      else if (bus_req.addr == SARSEQ_OFS_TRIG)
      begin
        s_next.rdata = {s_reg.trig_en, 7'h00} | SARSEQ_TRIG_ONES | s_reg.trig_rw;
      end
      else
      begin
        s_next.rdata = 8'h00;
      end
    end

    // register writes
    if (bus_req.wr)
    begin
      if (bus_req.addr == SARSEQ_OFS_CSR)
      begin
        if (!bus_req.wdata[SARSEQ_CSR_FLAG] && s_reg.flag_armed)
        begin
          s_next.flag = 1'b0;
        end
        s_next.flag_armed = 1'b0;
        s_next.irq_en = bus_req.wdata[SARSEQ_CSR_IRQ_EN];
        s_next.start = bus_req.wdata[SARSEQ_CSR_START];
        s_next.scan = bus_req.wdata[SARSEQ_CSR_SCAN];
        s_next.conv_time_select = bus_req.wdata[SARSEQ_CSR_CKS];
        s_next.chsel = bus_req.wdata[SARSEQ_CSR_CH_MSB:0];
      end
      else if (bus_req.addr == SARSEQ_OFS_TRIG)
      begin
        s_next.trig_en = bus_req.wdata[SARSEQ_TRIG_EN];
        s_next.trig_rw = bus_req.wdata & SARSEQ_TRIG_RW_MASK;
      end
    end

    // external start acts as a write of one to the start bit
    if (trig_edge)
    begin
      s_next.start = 1'b1;
    end

    // channel sequencer
    case (s_reg.fsm)
      SARSEQ_IDLE:
      begin
        if (s_next.start)
        begin
          s_next.fsm = SARSEQ_CONV;
          s_next.ch = s_next.scan ? 2'h0 : s_next.chsel[1:0];
          s_next.timer = '0;
        end
      end
      SARSEQ_CONV:
      begin
        if (!s_next.start)
        begin
          s_next.fsm = SARSEQ_IDLE;
        end
        else if (conv_done)
        begin
          s_next.result[s_reg.ch] = conv_data_in;
          s_next.timer = '0;
          if (last_ch)
          begin
            s_next.flag = 1'b1;
            if (s_reg.scan)
            begin
              s_next.ch = 2'h0;
            end
            else
            begin
              s_next.start = 1'b0;
              s_next.fsm = SARSEQ_IDLE;
            end
          end
          else
          begin
            s_next.ch = s_reg.ch + 2'h1;
          end
        end
        else
        begin
          s_next.timer = s_reg.timer + SARSEQ_TIMER_W'(1);
        end
      end
      default:
      begin
        s_next.fsm = SARSEQ_IDLE;
      end
    endcase

    // standby behaves as reset for the whole block
    if (standby)
    begin
      s_next = s_reset;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_reg <= s_reset;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign bus_rdata = s_reg.rdata;
  assign analog_channel = s_reg.ch;
  assign conv_active = (s_reg.fsm == SARSEQ_CONV);
  assign sample_strobe = conv_active && (s_reg.timer == '0);
  assign conv_end_irq = s_reg.flag && s_reg.irq_en;

endmodule // sarseq_top

`default_nettype wire

// [shared/sarseq_pkg.sv]
// package for the sar converter sequencer and register block
package sarseq_pkg;

  // byte offsets on the 8-bit register port
  localparam logic [3:0] SARSEQ_OFS_RES0_HI = 4'h0;
  localparam logic [3:0] SARSEQ_OFS_RES0_LO = 4'h1;
  localparam logic [3:0] SARSEQ_OFS_RES1_HI = 4'h2;
  localparam logic [3:0] SARSEQ_OFS_RES1_LO = 4'h3;
  localparam logic [3:0] SARSEQ_OFS_RES2_HI = 4'h4;
  localparam logic [3:0] SARSEQ_OFS_RES2_LO = 4'h5;
  localparam logic [3:0] SARSEQ_OFS_RES3_HI = 4'h6;
  localparam logic [3:0] SARSEQ_OFS_RES3_LO = 4'h7;
  localparam logic [3:0] SARSEQ_OFS_CSR = 4'h8;
  localparam logic [3:0] SARSEQ_OFS_TRIG = 4'h9;

  // control/status and trigger control field positions
  localparam int SARSEQ_CSR_FLAG = 7;
  localparam int SARSEQ_CSR_IRQ_EN = 6;
  localparam int SARSEQ_CSR_START = 5;
  localparam int SARSEQ_CSR_SCAN = 4;
  localparam int SARSEQ_CSR_CKS = 3;
  localparam int SARSEQ_CSR_CH_MSB = 2;
  localparam int SARSEQ_TRIG_EN = 7;

  // trigger control read pattern: bits 6..4 and 1 read as one
  localparam logic [7:0] SARSEQ_TRIG_ONES = 8'h72;
  localparam logic [7:0] SARSEQ_TRIG_RW_MASK = 8'h0d;

  // result layout: 10 bits placed in 15..6, lower 6 bits zero
  localparam int SARSEQ_RES_SHIFT = 6;
  localparam logic [15:0] SARSEQ_RES_RESET = 16'h0000;

  // conversion times: 1340 or 700 states of a 100 MHz clock
  localparam int SARSEQ_CLK_MHZ = 100;
  localparam int SARSEQ_CONV_SLOW_NS = 13400;
  localparam int SARSEQ_CONV_FAST_NS = 7000;
  localparam int SARSEQ_CONV_SLOW_CYC = (SARSEQ_CONV_SLOW_NS * SARSEQ_CLK_MHZ + 999) / 1000;
  localparam int SARSEQ_CONV_FAST_CYC = (SARSEQ_CONV_FAST_NS * SARSEQ_CLK_MHZ + 999) / 1000;
  localparam int SARSEQ_TIMER_W = 11;

  typedef enum logic [0:0] {
    SARSEQ_IDLE = 1'b0,
    SARSEQ_CONV = 1'b1
  } sarseq_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } sarseq_bus_req_t;

  typedef struct packed {
    sarseq_state_t fsm;
    logic flag;
    logic flag_armed;
    logic irq_en;
    logic start;
    logic scan;
    logic conv_time_select;
    logic [2:0] chsel;
    logic trig_en;
    logic [7:0] trig_rw;
    logic trig_prev;
    logic [1:0] ch;
    logic [SARSEQ_TIMER_W-1:0] timer;
    logic [3:0][9:0] result;
    logic [7:0] hold;
    logic [7:0] rdata;
  } sarseq_regs_t;

endpackage

// [tb/sarseq_top_sva.sv]
// port assertions for the sar sequencer top
`timescale 1ns/10ps
`default_nettype none
module sarseq_top_sva
  import sarseq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic standby,
  input wire sarseq_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic [1:0] analog_channel,
  input wire logic conv_active,
  input wire logic sample_strobe,
  input wire logic conv_end_irq
);
  logic [11:0] gap_reg;
  logic [11:0] gap_next;
  logic lo_rd;
  logic go_wr;
  assign lo_rd = bus_req.rd && !bus_req.addr[3] && bus_req.addr[0];
  assign go_wr = bus_req.wr && bus_req.addr == SARSEQ_OFS_CSR && bus_req.wdata[SARSEQ_CSR_START];
  always_comb gap_next = sample_strobe ? 12'h001 : gap_reg + 12'h001;
  always_ff @(posedge clk) gap_reg <= nrst ? gap_next : 12'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst || standby);
  lo_byte_zero_a: assert property (lo_rd |=> bus_rdata[5:0] == 6'h00)
    else $error("low result byte has nonzero low bits");
  rdata_stands_a: assert property (!$past(bus_req.rd) && !$past(standby) && $past(nrst)
    |-> $stable(bus_rdata))
    else $error("read data changed without a read");
  start_go_a: assert property (go_wr && !conv_active |=> conv_active)
    else $error("start write did not begin conversion");
  first_strobe_a: assert property ($rose(conv_active) |-> sample_strobe)
    else $error("conversion began without sample strobe");
  min_time_a: assert property (sample_strobe && $past(conv_active) |-> gap_reg >= 12'(SARSEQ_CONV_FAST_CYC))
    else $error("channel conversion too short");
  chan_hold_a: assert property (conv_active && $past(conv_active) && !sample_strobe |-> $stable(analog_channel))
    else $error("channel moved mid conversion");
  irq_rise_a: assert property ($rose(conv_end_irq) |-> $past(bus_req.wr) || !conv_active || sample_strobe)
    else $error("interrupt rose without cause");
  flag_clear_a: assert property ($fell(conv_end_irq) |-> $past(bus_req.wr) || $past(standby) || !$past(nrst))
    else $error("interrupt fell without a write");
  cover property ($rose(conv_end_irq));
  cover property (sample_strobe && analog_channel == 2'h1 && conv_active);
  cover property ($fell(conv_active));
endmodule // sarseq_top_sva
bind sarseq_top sarseq_top_sva u_sva (.clk(clk), .nrst(nrst), .standby(standby), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .analog_channel(analog_channel), .conv_active(conv_active),
  .sample_strobe(sample_strobe), .conv_end_irq(conv_end_irq));
`default_nettype wire

// [tb/test_sarseq_top.sv]
// self-checking bench for the sar sequencer top
`timescale 1ns/10ps
`default_nettype none
module test_sarseq_top
  import sarseq_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic standby = 1'b0;
  sarseq_bus_req_t req = '0;
  logic [7:0] rdata;
  logic pin = 1'b0;
  logic rise = 1'b1;
  logic [9:0] din = 10'h2a5;
  logic [1:0] chan;
  logic act;
  logic strobe;
  logic irq;
  int n_errors = 0;
  int checked = 0;
  sarseq_top dut (.clk(clk), .nrst(nrst), .standby(standby), .bus_req(req), .bus_rdata(rdata),
    .ext_trigger_pin(pin), .ext_trigger_rising(rise), .conv_data_in(din), .analog_channel(chan),
    .conv_active(act), .sample_strobe(strobe), .conv_end_irq(irq));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b0, 1'b1, a, d};
    @(posedge clk) req <= '0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic idle(input logic lvl);
    for (int i = 0; i < 3000 && act !== lvl; i++) @(negedge clk);
  endtask
  task automatic conv(input logic [7:0] csr, input int cyc);
    int n;
    n = 0;
    wr(SARSEQ_OFS_CSR, csr);
    @(negedge clk);
    while (act === 1'b1 && n < 3000)
    begin
      n++;
      @(negedge clk);
    end
    chk(16'(n), 16'(cyc));
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) rd(4'(a), 8'h00);
    rd(SARSEQ_OFS_TRIG, 8'h72);
    rd(4'hf, 8'h00);
    conv(8'h61, 1340);
    wr(SARSEQ_OFS_CSR, 8'h41);
    chk(16'(irq), 16'h0001);
    rd(SARSEQ_OFS_CSR, 8'hc1);
    wr(SARSEQ_OFS_CSR, 8'h41);
    chk(16'(irq), 16'h0000);
    rd(SARSEQ_OFS_RES1_HI, 8'ha9);
    rd(SARSEQ_OFS_RES1_LO, 8'h40);
    rd(SARSEQ_OFS_RES0_LO, 8'h40);
    rd(SARSEQ_OFS_RES0_HI, 8'h00);
    conv(8'h2b, 700);
    chk(16'(irq), 16'h0000);
    rd(SARSEQ_OFS_CSR, 8'h8b);
    wr(SARSEQ_OFS_CSR, 8'h08);
    @(posedge clk) din <= 10'h3ff;
    wr(SARSEQ_OFS_CSR, 8'h79);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(negedge clk);
    chk(16'(irq), 16'h0001);
    chk(16'(act), 16'h0001);
    rd(SARSEQ_OFS_RES0_HI, 8'hff);
    rd(SARSEQ_OFS_RES3_HI, 8'ha9);
    wr(SARSEQ_OFS_CSR, 8'h18);
    idle(1'b0);
    chk(16'(act), 16'h0000);
    @(posedge clk) din <= 10'h155;
    wr(SARSEQ_OFS_TRIG, 8'h80);
    rd(SARSEQ_OFS_TRIG, 8'hf2);
    wr(SARSEQ_OFS_CSR, 8'h0a);
    @(posedge clk) pin <= 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(act), 16'h0001);
    chk(16'(chan), 16'h0002);
    idle(1'b0);
    rd(SARSEQ_OFS_RES2_HI, 8'h55);
    @(posedge clk) rise <= 1'b0;
    @(posedge clk) pin <= 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(act), 16'h0001);
    @(posedge clk) standby <= 1'b1;
    @(posedge clk) standby <= 1'b0;
    @(negedge clk);
    chk(16'(act), 16'h0000);
    rd(SARSEQ_OFS_RES2_HI, 8'h00);
    conclude();
  end
  initial
  begin
    #300000;
    n_errors++;
    conclude();
  end
endmodule // test_sarseq_top
`default_nettype wire
